/* File: hw/pxc_pkg.sv */
package pxc_pkg;

  localparam int unsigned CFG_ADDR_W = 8;

  localparam logic [7:0] OFS_STATUS_DWORD = 8'h04;
  localparam logic [7:0] OFS_PCIX_CAP     = 8'he4;
  localparam logic [7:0] OFS_PCIX_STATUS  = 8'he8;

  localparam logic [7:0] PCIX_CAP_ID      = 8'h07;
  localparam logic [7:0] NEXT_PTR_MSI     = 8'hf0;
  localparam logic [7:0] NEXT_PTR_END     = 8'h00;

  localparam int unsigned STAT_INT_BIT    = 3;
  localparam int unsigned STAT_CAP_BIT    = 4;
  localparam int unsigned STAT_66_BIT     = 5;
  localparam int unsigned STAT_UDF_BIT    = 6;
  localparam int unsigned STAT_FB2B_BIT   = 7;
  localparam int unsigned STAT_DPR_BIT    = 8;
  localparam int unsigned STAT_DEVSEL_LO  = 9;
  localparam int unsigned STAT_STA_BIT    = 11;
  localparam int unsigned STAT_RTA_BIT    = 12;
  localparam int unsigned STAT_RMA_BIT    = 13;
  localparam int unsigned STAT_SSE_BIT    = 14;
  localparam int unsigned STAT_DPE_BIT    = 15;
  localparam logic [1:0]  DEVSEL_MEDIUM   = 2'h1;

  localparam logic [15:0] PCIX_CMD_WR_MASK = 16'h007f;
  localparam logic [15:0] PCIX_CMD_RESET   = 16'h0002;
  localparam logic [12:0] READ_BYTES_BASE  = 13'h0200;

  // Sticky error flags of the status word, also used as the event vector.
  typedef struct packed {
    logic detected_parity;
    logic signaled_system_error;
    logic received_master_abort;
    logic received_target_abort;
    logic signaled_target_abort;
    logic data_parity_reported;
  } pxc_flags_type;

  typedef struct packed {
    logic [8:0] reserved;
    logic [2:0] split_code;
    logic [1:0] read_code;
    logic       relaxed_order_enable;
    logic       parity_recovery_enable;
  } pxc_cmd_type;

endpackage

/* File: hw/pxc_config_regs.sv */
`timescale 1ns/1ps
// Overview of operation
// - Status bit 3 follows the internal interrupt while the variant implements it.
// - A pending interrupt with interrupt-disable clear drives the interrupt pin or stream.
// - Status bit 4 reads one: a capabilities list is present.
// - Status bit 5 reads one: the device runs at 66 MHz.
// - Status bit 6, user-definable features, reads zero.
// - Status bit 7 reads FAST_B2B_CAPABLE in PCI mode and zero in PCI-X mode.
// - Status bits 8 and 11 to 15 are error flags resetting to zero.
// - Status bits 10:9 read 01, medium select timing.
// - PCI-X registers are accessible always; command bits 1:0 act only in PCI-X mode.
// - Capability dword sits at E4h: ID, next pointer, command; status at E8h.
// - Capability ID byte is read-only and returns 7.
// - Next pointer returns F0, or zero when message interrupts are disabled in PCI mode.
// - Command bit 0 set selects parity recovery over system error; resets zero.
// - Command bit 0 clear: each new data parity flag pulses system error if enabled.
// - Command bit 1 resets to one and enables the relaxed-ordering attribute.
// - Command bits 3:2 cap read sequences at 512, 1024, 2048 or 4096 bytes.
// - Command bits 15:7 read zero.
// - The int_disable input suppresses signalling of the pending interrupt.
module pxc_config_regs
  import pxc_pkg::*;
#(
  parameter bit INT_STATUS_IMPL  = 1'b1,
  parameter bit FAST_B2B_CAPABLE = 1'b0,
  parameter bit USE_STREAM_PORT  = 1'b0
) (
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire logic                  cfg_rd,
  input  wire logic                  cfg_wr,
  input  wire logic [CFG_ADDR_W-1:0] cfg_addr,
  input  wire logic [3:0]            cfg_byte_en,
  input  wire logic [31:0]           cfg_wdata,
  output logic                       cfg_hit,
  output logic                       cfg_rvalid,
  output logic      [31:0]           cfg_rdata,
  input  wire logic                  pcix_mode,
  input  wire logic                  msi_nvm_disable,
  input  wire logic                  serr_enable,
  input  wire logic                  int_disable,
  input  wire logic                  int_pending,
  input  wire pxc_flags_type         bus_events,
  input  wire logic                  split_request,
  input  wire logic                  split_complete,
  output logic                       split_grant,
  output logic                       inta_n_o,
  output logic                       inta_oe,
  output logic                       stream_int_valid,
  output logic                       stream_int_level,
  output logic                       serr_n_o,
  output logic                       serr_oe,
  output logic                       parity_recovery_active,
  output logic                       relaxed_order_enable,
  output logic      [12:0]           max_read_bytes,
  output logic      [5:0]            split_limit,
  output logic                       msi_visible
);

  function automatic logic [15:0] lane_mask(input logic [1:0] be, input logic [15:0] d);
    lane_mask = {be[1] ? d[15:8] : 8'h00, be[0] ? d[7:0] : 8'h00};
  endfunction

  function automatic logic [12:0] read_bytes(input logic [1:0] code);
    read_bytes = READ_BYTES_BASE << code;
  endfunction

  function automatic logic [5:0] split_count(input logic [2:0] code);
    case (code)
      3'h0: split_count = 6'h01;
      3'h1: split_count = 6'h02;
      3'h2: split_count = 6'h03;
      3'h3: split_count = 6'h04;
      3'h4: split_count = 6'h08;
      3'h5: split_count = 6'h0c;
      3'h6: split_count = 6'h10;
      default: split_count = 6'h20;
    endcase
  endfunction

  pxc_flags_type flags_reg;
  pxc_flags_type flags_next;
  pxc_flags_type flags_clear;
  pxc_cmd_type   cmd_reg;
  logic [15:0]   cmd_next;
  logic [15:0]   status_word;
  logic [15:0]   stat_wr_ones;
  logic [15:0]   cmd_wr_bits;
  logic [15:0]   cmd_wr_lanes;
  logic [7:0]    next_ptr;
  logic          hit_status;
  logic          hit_cap;
  logic          msi_off_reg;
  logic          dpr_prev_reg;
  logic          serr_pulse_reg;
  logic          intr_level;
  logic          intr_level_reg;
  logic          split_busy_reg;
  logic          recovery_on;

  assign hit_status = (cfg_addr == OFS_STATUS_DWORD);
  assign hit_cap    = (cfg_addr == OFS_PCIX_CAP);
  // The PCI-X status dword and the command half of 04h are answered by their own logic.
  assign cfg_hit    = hit_status | hit_cap;

  // Parity recovery and relaxed ordering only act in PCI-X mode; read and split limits always apply.
  assign recovery_on = cmd_reg.parity_recovery_enable & pcix_mode;

  always_comb begin
    status_word                              = 16'h0000;
    status_word[STAT_INT_BIT]                = INT_STATUS_IMPL & int_pending;
    status_word[STAT_CAP_BIT]                = 1'b1;
    status_word[STAT_66_BIT]                 = 1'b1;
    status_word[STAT_UDF_BIT]                = 1'b0;
    status_word[STAT_FB2B_BIT]               = FAST_B2B_CAPABLE & ~pcix_mode;
    status_word[STAT_DPR_BIT]                = flags_reg.data_parity_reported;
    status_word[STAT_DEVSEL_LO+1:STAT_DEVSEL_LO] = DEVSEL_MEDIUM;
    status_word[STAT_STA_BIT]                = flags_reg.signaled_target_abort;
    status_word[STAT_RTA_BIT]                = flags_reg.received_target_abort;
    status_word[STAT_RMA_BIT]                = flags_reg.received_master_abort;
    status_word[STAT_SSE_BIT]                = flags_reg.signaled_system_error;
    status_word[STAT_DPE_BIT]                = flags_reg.detected_parity;
  end

  // Message interrupts can only be hidden in conventional mode.
  assign next_ptr = (msi_off_reg & ~pcix_mode) ? NEXT_PTR_END : NEXT_PTR_MSI;

  // Status clears: a written one clears, a zero or a disabled lane leaves the flag alone.
  assign stat_wr_ones = (cfg_wr & hit_status) ?
                        lane_mask(cfg_byte_en[3:2], cfg_wdata[31:16]) : 16'h0000;

  always_comb begin
    flags_clear.detected_parity       = stat_wr_ones[STAT_DPE_BIT];
    flags_clear.signaled_system_error = stat_wr_ones[STAT_SSE_BIT];
    flags_clear.received_master_abort = stat_wr_ones[STAT_RMA_BIT];
    flags_clear.received_target_abort = stat_wr_ones[STAT_RTA_BIT];
    flags_clear.signaled_target_abort = stat_wr_ones[STAT_STA_BIT];
    flags_clear.data_parity_reported  = stat_wr_ones[STAT_DPR_BIT];
  end

  // An event in the same cycle as its clear wins, so no error goes unseen.
  always_comb begin
    flags_next = (flags_reg & ~flags_clear) | bus_events;
    flags_next.signaled_system_error = flags_next.signaled_system_error | serr_pulse_reg;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // Only bits 6:0 hold state; the upper bits always read zero.
  assign cmd_wr_lanes = (cfg_wr & hit_cap) ?
                        lane_mask(cfg_byte_en[3:2], 16'hffff) : 16'h0000;
  assign cmd_wr_bits  = cmd_wr_lanes & PCIX_CMD_WR_MASK;
  assign cmd_next     = (cmd_reg & ~cmd_wr_bits) | (cfg_wdata[31:16] & cmd_wr_bits);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cmd_reg <= PCIX_CMD_RESET;
    end else begin
      cmd_reg <= cmd_next;
    end
  end

  // The nonvolatile option is a level caught after reset release, never under it.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      msi_off_reg <= 1'b0;
    end else begin
      msi_off_reg <= msi_nvm_disable;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cfg_rvalid <= 1'b0;
      cfg_rdata  <= 32'h0000_0000;
    end else begin
      cfg_rvalid <= cfg_rd;
      if (cfg_rd & hit_status) begin
        cfg_rdata <= {status_word, 16'h0000};
      end else if (cfg_rd & hit_cap) begin
        cfg_rdata <= {cmd_reg, next_ptr, PCIX_CAP_ID};
      end else begin
        cfg_rdata <= 32'h0000_0000;
      end
    end
  end

  // System error is a one-clock pulse per rising parity flag.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dpr_prev_reg   <= 1'b0;
      serr_pulse_reg <= 1'b0;
    end else begin
      dpr_prev_reg   <= flags_reg.data_parity_reported;
      serr_pulse_reg <= flags_reg.data_parity_reported & ~dpr_prev_reg
                        & serr_enable & ~recovery_on;
    end
  end

  assign serr_oe  = serr_pulse_reg;
  assign serr_n_o = 1'b0;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      parity_recovery_active <= 1'b0;
    end else begin
      parity_recovery_active <= flags_reg.data_parity_reported & recovery_on;
    end
  end

  assign intr_level = int_pending & ~int_disable;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      intr_level_reg   <= 1'b0;
      inta_oe          <= 1'b0;
      stream_int_valid <= 1'b0;
      stream_int_level <= 1'b0;
    end else begin
      intr_level_reg   <= intr_level;
      inta_oe          <= intr_level & ~USE_STREAM_PORT;
      stream_int_valid <= USE_STREAM_PORT & (intr_level != intr_level_reg);
      stream_int_level <= intr_level;
    end
  end

  assign inta_n_o = 1'b0;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      relaxed_order_enable <= 1'b0;
      max_read_bytes       <= READ_BYTES_BASE;
      split_limit          <= 6'h01;
      msi_visible          <= 1'b1;
    end else begin
      relaxed_order_enable <= cmd_reg.relaxed_order_enable & pcix_mode;
      max_read_bytes       <= read_bytes(cmd_reg.read_code);
      split_limit          <= split_count(cmd_reg.split_code);
      msi_visible          <= (next_ptr == NEXT_PTR_MSI);
    end
  end

  // The programmed limit is advisory; the engine never runs two splits at once.
  assign split_grant = split_request & ~split_busy_reg;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      split_busy_reg <= 1'b0;
    end else if (split_grant) begin
      split_busy_reg <= 1'b1;
    end else if (split_complete) begin
      split_busy_reg <= 1'b0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_int_status;
    cfg_rd && hit_status |=> cfg_rdata[16+STAT_INT_BIT] == (INT_STATUS_IMPL && $past(int_pending));
  endproperty
  a_int_status: assert property (p_int_status) else $error("interrupt status bit wrong");

  property p_inta;
    !USE_STREAM_PORT ##0 int_pending && !int_disable |=> inta_oe;
  endproperty
  a_inta: assert property (p_inta) else $error("interrupt pin not driven");

  property p_int_mask;
    int_disable |=> !inta_oe && !stream_int_level;
  endproperty
  a_int_mask: assert property (p_int_mask) else $error("disabled interrupt signalled");

  property p_fixed_bits;
    cfg_rd && hit_status |=> cfg_rdata[20] && cfg_rdata[21] && !cfg_rdata[22]
                             && cfg_rdata[26:25] == 2'h1 && cfg_rdata[18:16] == 3'h0;
  endproperty
  a_fixed_bits: assert property (p_fixed_bits) else $error("fixed status bits wrong");

  property p_fb2b;
    cfg_rd && hit_status && pcix_mode |=> !cfg_rdata[23];
  endproperty
  a_fb2b: assert property (p_fb2b) else $error("fast back-to-back set in PCI-X mode");

  // The flag may only drop in the cycle after a write of one has reached it.
  property p_flag_set;
    bus_events.received_master_abort |=> flags_reg.received_master_abort
      ##1 (flags_reg.received_master_abort || $past(stat_wr_ones[STAT_RMA_BIT]));
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("error flag not sticky");

  property p_flag_clear;
    cfg_wr && hit_status && cfg_byte_en[3] && cfg_wdata[29] && !bus_events.received_master_abort
      |=> !flags_reg.received_master_abort;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("write one did not clear");

  property p_cap_dword;
    cfg_rd && hit_cap |=> cfg_rdata[7:0] == 8'h07 && cfg_rdata[31:23] == 9'h000
                          && cfg_rdata[15:8] == $past(next_ptr);
  endproperty
  a_cap_dword: assert property (p_cap_dword) else $error("capability dword wrong");

  property p_next_ptr;
    msi_off_reg && !pcix_mode |-> next_ptr == 8'h00;
  endproperty
  a_next_ptr: assert property (p_next_ptr) else $error("hidden MSI still linked");

  property p_serr;
    $rose(flags_reg.data_parity_reported) && serr_enable && !recovery_on |=> serr_oe ##1 !serr_oe;
  endproperty
  a_serr: assert property (p_serr) else $error("system error pulse missing");

  property p_recover;
    recovery_on |=> !serr_oe;
  endproperty
  a_recover: assert property (p_recover) else $error("system error during recovery");

  property p_relaxed;
    !pcix_mode |=> !relaxed_order_enable;
  endproperty
  a_relaxed: assert property (p_relaxed) else $error("relaxed order outside PCI-X");

  property p_read_cap;
    ##1 max_read_bytes == (13'h0200 << $past(cmd_reg.read_code));
  endproperty
  a_read_cap: assert property (p_read_cap) else $error("read byte cap wrong");

  property p_split_limit;
    $past(cmd_reg.split_code) == 3'h7 |-> split_limit == 6'h20;
  endproperty
  a_split_limit: assert property (p_split_limit) else $error("split limit decode wrong");

  property p_one_split;
    split_grant |=> split_busy_reg && !split_grant;
  endproperty
  a_one_split: assert property (p_one_split) else $error("second split granted");

  c_serr:      cover property (serr_oe);
  c_clear:     cover property (cfg_wr && hit_status && |flags_reg);
  c_split:     cover property (split_grant ##[1:20] split_complete);
  c_msi_hide:  cover property (cfg_rd && hit_cap && next_ptr == 8'h00);

endmodule

/* File: verification/pxc_host_model.sv */
`timescale 1ns/1ps
module pxc_host_model
  import pxc_pkg::*;
(
  input  wire logic        clk,
  output logic             cfg_rd,
  output logic             cfg_wr,
  output logic [7:0]       cfg_addr,
  output logic [3:0]       cfg_byte_en,
  output logic [31:0]      cfg_wdata,
  input  wire logic        cfg_hit,
  input  wire logic        cfg_rvalid,
  input  wire logic [31:0] cfg_rdata,
  input  wire logic        inta_n_o,
  input  wire logic        inta_oe,
  input  wire logic        serr_n_o,
  input  wire logic        serr_oe,
  output logic             inta_n_wire,
  output logic             serr_n_wire
);
  // Both lines are open drain and pulled up on the board.
  assign inta_n_wire = inta_oe ? inta_n_o : 1'b1;
  assign serr_n_wire = serr_oe ? serr_n_o : 1'b1;

  initial begin
    cfg_rd = 1'b0;
    cfg_wr = 1'b0;
    cfg_addr = 8'h5a;
    cfg_byte_en = 4'h0;
    cfg_wdata = 32'ha5a5_a5a5;
  end

  // Idle address and data are inverted so a stale value is never mistaken for a live one.
  task automatic cfg_read(input logic [7:0] a, output logic [31:0] d, output logic v,
                          output logic h);
    @(posedge clk);
    #1;
    cfg_rd = 1'b1;
    cfg_addr = a;
    cfg_byte_en = 4'hf;
    #1;
    h = cfg_hit;
    @(posedge clk);
    #1;
    v = cfg_rvalid;
    d = cfg_rdata;
    cfg_rd = 1'b0;
    cfg_addr = ~a;
  endtask

  // Software clears a status flag only by writing a one to it.
  task automatic cfg_write(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge clk);
    #1;
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_byte_en = be;
    cfg_wdata = d;
    @(posedge clk);
    #1;
    cfg_wr = 1'b0;
    cfg_addr = ~a;
    cfg_wdata = ~d;
  endtask
endmodule

/* File: verification/tb_pci_status_and_pcix_capability.sv */
`timescale 1ns/1ps
module tb_pci_status_and_pcix_capability;
  import pxc_pkg::*;
  typedef struct packed {
    logic [15:0] wr;
    logic [15:0] cmd;
    logic [12:0] bytes;
    logic [5:0]  limit;
  } pxc_row_type;
  localparam logic [15:0] ST0 = 16'h0230;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic pcix_mode = 1'b1;
  logic msi_nvm_disable = 1'b0;
  logic serr_enable = 1'b0;
  logic int_disable = 1'b0;
  logic int_pending = 1'b0;
  logic split_request = 1'b0;
  logic split_complete = 1'b0;
  pxc_flags_type bus_events = '0;
  logic cfg_rd, cfg_wr, cfg_hit, cfg_rvalid, split_grant, inta_n_o, inta_oe;
  logic stream_int_valid, stream_int_level, serr_n_o, serr_oe, inta_n_wire, serr_n_wire;
  logic parity_recovery_active, relaxed_order_enable, msi_visible;
  logic [7:0]  cfg_addr;
  logic [3:0]  cfg_byte_en;
  logic [31:0] cfg_wdata, cfg_rdata;
  logic [12:0] max_read_bytes;
  logic [5:0]  split_limit;
  pxc_row_type rows [8];
  int failures = 0;
  int tests_run = 0;
  int cycles = 0;

  pxc_config_regs u_pxc_config_regs (.clk(clk), .reset(reset), .cfg_rd(cfg_rd),
    .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata),
    .cfg_hit(cfg_hit), .cfg_rvalid(cfg_rvalid), .cfg_rdata(cfg_rdata), .pcix_mode(pcix_mode),
    .msi_nvm_disable(msi_nvm_disable), .serr_enable(serr_enable), .int_disable(int_disable),
    .int_pending(int_pending), .bus_events(bus_events), .split_request(split_request),
    .split_complete(split_complete), .split_grant(split_grant), .inta_n_o(inta_n_o),
    .inta_oe(inta_oe), .stream_int_valid(stream_int_valid),
    .stream_int_level(stream_int_level), .serr_n_o(serr_n_o), .serr_oe(serr_oe),
    .parity_recovery_active(parity_recovery_active),
    .relaxed_order_enable(relaxed_order_enable), .max_read_bytes(max_read_bytes),
    .split_limit(split_limit), .msi_visible(msi_visible));

  pxc_host_model u_pxc_host_model (.clk(clk), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
    .cfg_addr(cfg_addr), .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata), .cfg_hit(cfg_hit),
    .cfg_rvalid(cfg_rvalid), .cfg_rdata(cfg_rdata), .inta_n_o(inta_n_o), .inta_oe(inta_oe),
    .serr_n_o(serr_n_o), .serr_oe(serr_oe), .inta_n_wire(inta_n_wire),
    .serr_n_wire(serr_n_wire));

  always #20 clk = ~clk;

  task automatic finish_test();
    if (failures == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // The whole run needs about 110 cycles; a hang is cut well after that.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      finish_test();
    end
  end

  task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_bit(input string n, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e,
                        input logic hx);
    logic [31:0] d;
    logic v, h;
    u_pxc_host_model.cfg_read(a, d, v, h);
    chk_bit("rvalid", 1'b1, v);
    chk_bit("hit", hx, h);
    chk_word(n, e, d);
  endtask

  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    u_pxc_host_model.cfg_write(a, be, d);
  endtask

  task automatic pulse_events(input pxc_flags_type ev);
    bus_events = ev;
    @(posedge clk);
    #1;
    bus_events = '0;
  endtask

  initial begin
    rows[0] = '{16'hff80, 16'h0000, 13'h0200, 6'h01};
    rows[1] = '{16'hff97, 16'h0017, 13'h0400, 6'h02};
    rows[2] = '{16'hffaa, 16'h002a, 13'h0800, 6'h03};
    rows[3] = '{16'hffbd, 16'h003d, 13'h1000, 6'h04};
    rows[4] = '{16'hffc0, 16'h0040, 13'h0200, 6'h08};
    rows[5] = '{16'hffd4, 16'h0054, 13'h0400, 6'h0c};
    rows[6] = '{16'hffe8, 16'h0068, 13'h0800, 6'h10};
    rows[7] = '{16'hfffe, 16'h007e, 13'h1000, 6'h20};
    repeat (16) @(posedge clk);
    #1;
    reset = 1'b0;
    rd_chk("status", 8'h04, {ST0, 16'h0}, 1'b1);
    rd_chk("cap", 8'he4, 32'h0002_f007, 1'b1);
    rd_chk("unclaimed", 8'he8, 32'h0, 1'b0);
    chk_bit("msi_visible", 1'b1, msi_visible);
    for (int i = 0; i < 8; i++) begin
      wr(8'he4, 4'b1100, {rows[i].wr, 16'h0});
      rd_chk("cmd", 8'he4, {rows[i].cmd, 16'hf007}, 1'b1);
      chk_word("bytes", {19'h0, rows[i].bytes}, {19'h0, max_read_bytes});
      chk_word("limit", {26'h0, rows[i].limit}, {26'h0, split_limit});
      chk_bit("relaxed", rows[i].cmd[1], relaxed_order_enable);
    end
    int_pending = 1'b1;
    @(posedge clk);
    #1;
    chk_bit("inta", 1'b0, inta_n_wire);
    chk_bit("stream_level", 1'b1, stream_int_level);
    chk_bit("stream_valid", 1'b0, stream_int_valid);
    rd_chk("status", 8'h04, {ST0 | 16'h0008, 16'h0}, 1'b1);
    int_disable = 1'b1;
    @(posedge clk);
    #1;
    chk_bit("inta", 1'b1, inta_n_wire);
    chk_bit("stream_level", 1'b0, stream_int_level);
    chk_bit("stream_valid", 1'b0, stream_int_valid);
    // The status bit reports the internal interrupt even while signalling is masked.
    rd_chk("status", 8'h04, {ST0 | 16'h0008, 16'h0}, 1'b1);
    int_pending = 1'b0;
    int_disable = 1'b0;
    pulse_events(6'b101110);
    rd_chk("status", 8'h04, {ST0 | 16'hb800, 16'h0}, 1'b1);
    wr(8'h04, 4'b1000, 32'h0);
    rd_chk("status", 8'h04, {ST0 | 16'hb800, 16'h0}, 1'b1);
    wr(8'h04, 4'b1000, 32'h2000_0000);
    rd_chk("status", 8'h04, {ST0 | 16'h9800, 16'h0}, 1'b1);
    // A target-abort event and its clear meet at one edge; the event must win.
    fork
      wr(8'h04, 4'b1000, 32'h0800_0000);
      begin
        @(posedge clk);
        #1;
        pulse_events(6'b000010);
      end
    join
    rd_chk("status", 8'h04, {ST0 | 16'h9800, 16'h0}, 1'b1);
    wr(8'h04, 4'hf, 32'hffff_ffff);
    rd_chk("status", 8'h04, {ST0, 16'h0}, 1'b1);
    serr_enable = 1'b1;
    pulse_events(6'b000001);
    @(posedge clk);
    #1;
    chk_bit("serr", 1'b0, serr_n_wire);
    @(posedge clk);
    #1;
    chk_bit("serr", 1'b1, serr_n_wire);
    rd_chk("status", 8'h04, {ST0 | 16'h4100, 16'h0}, 1'b1);
    wr(8'h04, 4'b1000, 32'hff00_0000);
    wr(8'he4, 4'b1100, 32'h0001_0000);
    pulse_events(6'b000001);
    @(posedge clk);
    #1;
    chk_bit("serr_oe", 1'b0, serr_oe);
    chk_bit("recovery", 1'b1, parity_recovery_active);
    pcix_mode = 1'b0;
    @(posedge clk);
    #1;
    @(posedge clk);
    #1;
    chk_bit("recovery", 1'b0, parity_recovery_active);
    rd_chk("cap", 8'he4, 32'h0001_f007, 1'b1);
    // The command stays writable in conventional mode but bits 1:0 only act in PCI-X mode.
    wr(8'he4, 4'b1100, 32'h0003_0000);
    rd_chk("cap", 8'he4, 32'h0003_f007, 1'b1);
    chk_bit("relaxed", 1'b0, relaxed_order_enable);
    msi_nvm_disable = 1'b1;
    rd_chk("cap", 8'he4, 32'h0003_0007, 1'b1);
    chk_bit("msi_visible", 1'b0, msi_visible);
    pcix_mode = 1'b1;
    rd_chk("cap", 8'he4, 32'h0003_f007, 1'b1);
    chk_bit("relaxed", 1'b1, relaxed_order_enable);
    split_request = 1'b1;
    #1;
    chk_bit("grant", 1'b1, split_grant);
    repeat (4) begin
      @(posedge clk);
      #1;
      chk_bit("grant", 1'b0, split_grant);
    end
    split_complete = 1'b1;
    @(posedge clk);
    #1;
    split_complete = 1'b0;
    chk_bit("grant", 1'b1, split_grant);
    split_request = 1'b0;
    reset = 1'b1;
    @(posedge clk);
    #1;
    reset = 1'b0;
    chk_bit("relaxed", 1'b0, relaxed_order_enable);
    rd_chk("cap", 8'he4, 32'h0002_f007, 1'b1);
    chk_bit("relaxed", 1'b1, relaxed_order_enable);
    rd_chk("status", 8'h04, {ST0, 16'h0}, 1'b1);
    finish_test();
  end
endmodule
